// [hw/alu_if.sv]
// Carrier between the sequencer and its 8-bit arithmetic unit
`timescale 1ns/1ps
interface alu_if;
   import seq_pkg::*;
   alu_func_e func;
   logic dest_mem;
   logic [`DW-1:0] a;
   logic [`DW-1:0] b;
   logic [3:0] sin;
   logic [`DW-1:0] y;
   logic [3:0] flags;
   logic [3:0] upd;
   modport core(output func, dest_mem, a, b, sin, input y, flags, upd);
   modport unit(input func, dest_mem, a, b, sin, output y, flags, upd);
endinterface

// [hw/fetch_sequencer.sv]
// Four-phase fetch/execute sequencer with counter, return stack and APB
// Notes on behaviour
// RQ1: four phases derived from pclk make one instruction cycle.
// RQ2: phase one advances the counter and fetches; others decode and execute.
// RQ3: next fetch overlaps current execution; plain instructions take one cycle.
// RQ4: jump and call flush the prefetched word; two cycles in total.
// RQ5: a satisfied skip discards the prefetched word and runs a dummy cycle.
// RQ6: counter steps by one unless control goes elsewhere.
// RQ7: counter is ten bits: two high bits plus a software low byte.
// RQ8: jumps, calls, interrupts and reset load the target straight in.
// RQ9: low byte write branches inside the current 256-word page.
// RQ10: a low byte branch inserts one dummy cycle.
// RQ11: two-level return stack of counter values, hidden from software.
// RQ12: call or interrupt acknowledge pushes the counter.
// RQ13: subroutine and interrupt return pop the counter back.
// RQ14: after reset the stack is empty.
// RQ15: with a full stack an interrupt waits pending until a return.
// RQ16: a call on a full stack still runs; oldest entry is lost.
// RQ17: software should not nest calls deeper than the stack.
// RQ18: 8-bit unit: add, subtract, carry forms, decimal, logic, rotate, step.
// RQ19: result goes to the named register; status flags updated.
// RQ20: data moves through the accumulator; direct and indirect operands.
// RQ21: reset loads the counter with location zero.
// RQ22: sequential stepping wraps from the top address to zero.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "seq_consts.svh"
module fetch_sequencer #(
   parameter logic [`PC_W-1:0] IRQ_VECTOR = 10'h004
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Program memory
   output logic [`PC_W-1:0] pmem_addr,
   input wire logic [`IR_W-1:0] pmem_rdata,
   // Data memory
   output logic [`DW-1:0] dmem_addr,
   output logic [`DW-1:0] dmem_wdata,
   output logic dmem_we,
   input wire logic [`DW-1:0] dmem_rdata,
   // Interrupt
   input wire logic irq_event,
   output logic irq_ack,
   // Phase view
   output logic [3:0] instruction_phase_clocks
);
   import seq_pkg::*;

   seq_state_s st;
   seq_state_s next_st;
   logic setup;
   logic access;
   logic step_end;
   logic ack_ok;
   logic wr_en;
   logic [`DW-1:0] wr_val;
   logic [`DW-1:0] opnd;
   logic [`PC_W-1:0] seq_pc;
   logic [`PC_W-1:0] top_ret;
   logic [`PC_W-1:0] pcl_target;

   alu_if alu();

   seq_alu u_alu (
      .bus(alu.unit)
   );

   // ***************************************
   // Decoders
   // ***************************************
   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a == `OFF_COUNTER_LOW) || (a == `OFF_CONTROL) ||
                (a == `OFF_STATE);
   endfunction

   // Internal registers shadow the matching data addresses
   function automatic logic [`DW-1:0] operand_of(
      input logic [`DW-1:0] a,
      input logic [`DW-1:0] rd,
      input seq_state_s s
   );
      operand_of = rd;
      if (a == `DADDR_PTR) begin
         operand_of = s.ptr;
      end else if (a == `DADDR_STATUS) begin
         operand_of = {4'h0, s.status};
      end else if (a == `DADDR_PCL) begin
         operand_of = s.fetch_addr[7:0];
      end
   endfunction

   assign setup = psel && !penable;
   assign access = psel && penable;
   assign step_end = st.run && (st.phase == PH_T4);
   assign seq_pc = st.fetch_addr + 10'h001; // [RQ22]
   assign pcl_target = {st.fetch_addr[9:8], st.pcl_val};
   assign top_ret = (st.level == 2'h0) ? st.stack[0] :
                    st.stack[st.level[1] ? 1 : 0];
   // Interrupt waits while the stack is full or control moves anyway
   assign ack_ok = st.irq_pending && (st.level != 2'h2) &&
                   !st.redir && !st.pcl_req; // [RQ15]
   assign opnd = operand_of(st.dmem_addr, dmem_rdata, st); // [RQ20]

   assign alu.func = alu_func_e'(st.ir[12:9]);
   assign alu.dest_mem = st.ir[`IR_DEST];
   assign alu.a = st.acc;
   assign alu.b = opnd;
   assign alu.sin = st.status;

   // ***************************************
   // Sequencing, stack and register bus
   // ***************************************
   always_comb begin
      next_st = st;
      next_st.irq_ack = 1'b0;
      wr_en = 1'b0;
      wr_val = 8'h00;
      if (st.run) begin
         unique case (st.phase)
            PH_T1: next_st.phase = PH_T2; // [RQ1]
            PH_T2: begin
               next_st.phase = PH_T3;
               // Address zero goes through the pointer
               next_st.dmem_addr = (st.ir[7:0] == `DADDR_IND) ?
                                   st.ptr : st.ir[7:0]; // [RQ20]
            end
            PH_T3: begin
               next_st.phase = PH_T4;
               next_st.redir = 1'b0;
               next_st.push = 1'b0;
               next_st.pop = 1'b0;
               next_st.target = seq_pc;
               if (st.ir_valid && !st.ir[`IR_BRANCH]) begin
                  next_st.status = (st.status & ~alu.upd) |
                                   (alu.flags & alu.upd); // [RQ19]
                  if (st.ir[`IR_DEST]) begin
                     wr_en = 1'b1;
                     wr_val = alu.y;
                  end else begin
                     next_st.acc = alu.y; // [RQ18] [RQ19]
                  end
               end else if (st.ir_valid && !st.ir[`IR_MISC]) begin
                  next_st.redir = 1'b1; // [RQ4] [RQ8]
                  next_st.target = st.ir[`PC_W-1:0];
                  next_st.push = st.ir[`IR_CALL]; // [RQ12]
               end else if (st.ir_valid) begin
                  case (st.ir[10:8])
                     `SUB_SZ: next_st.redir = (opnd == 8'h00); // [RQ5]
                     `SUB_SNZ: next_st.redir = (opnd != 8'h00);
                     `SUB_SIZ: begin
                        wr_en = 1'b1;
                        wr_val = opnd + 8'h01;
                        next_st.redir = (wr_val == 8'h00);
                     end
                     `SUB_SDZ: begin
                        wr_en = 1'b1;
                        wr_val = opnd - 8'h01;
                        next_st.redir = (wr_val == 8'h00);
                     end
                     `SUB_RET, `SUB_INTERRUPT_RETURN: begin
                        next_st.redir = 1'b1; // [RQ13]
                        next_st.pop = 1'b1;
                        next_st.target = top_ret;
                     end
                     default: ;
                  endcase
               end
            end
            PH_T4: begin
               next_st.phase = PH_T1;
               next_st.dmem_we = 1'b0;
               // Prefetched word becomes the next executed one
               next_st.ir = pmem_rdata; // [RQ3]
               next_st.ir_valid = !(st.redir || st.pcl_req || ack_ok);
               if (st.pcl_req) begin
                  next_st.fetch_addr = pcl_target; // [RQ9] [RQ10]
                  next_st.pcl_req = 1'b0;
               end else if (st.redir) begin
                  next_st.fetch_addr = st.target; // [RQ4] [RQ5]
               end else if (ack_ok) begin
                  next_st.fetch_addr = IRQ_VECTOR; // [RQ8]
                  next_st.irq_pending = 1'b0;
                  next_st.irq_ack = 1'b1;
               end else begin
                  next_st.fetch_addr = seq_pc; // [RQ2] [RQ6]
               end
               if (st.push || ack_ok) begin
                  if (st.level == 2'h2) begin
                     // Overflow drops the oldest return address
                     next_st.stack[0] = st.stack[1]; // [RQ16]
                     next_st.stack[1] = st.fetch_addr;
                  end else begin
                     next_st.stack[st.level[0]] = st.fetch_addr; // [RQ12]
                     next_st.level = st.level + 2'h1;
                  end
               end else if (st.pop && st.level != 2'h0) begin
                  next_st.level = st.level - 2'h1; // [RQ13]
               end
            end
         endcase
      end
      // Result write-back, internal registers first
      if (wr_en) begin
         if (st.dmem_addr == `DADDR_PTR) begin
            next_st.ptr = wr_val;
         end else if (st.dmem_addr == `DADDR_STATUS) begin
            next_st.status = wr_val[3:0];
         end else if (st.dmem_addr == `DADDR_PCL) begin
            next_st.redir = 1'b1; // [RQ9] [RQ10]
            next_st.target = {st.fetch_addr[9:8], wr_val};
         end else begin
            next_st.dmem_we = 1'b1; // [RQ19]
            next_st.dmem_wdata = wr_val;
         end
      end
      // Set after clear: a new event in the clearing cycle survives
      if (irq_event) begin
         next_st.irq_pending = 1'b1; // [RQ15]
      end
      if (setup) begin
         next_st.pslverr = !reg_hit(paddr);
         case (paddr)
            `OFF_COUNTER_LOW: next_st.prdata = {24'h000000,
                                                st.fetch_addr[7:0]};
            `OFF_CONTROL: next_st.prdata = {31'h00000000, st.run};
            // Stack contents and level stay invisible here
            `OFF_STATE: next_st.prdata = {7'h00, st.irq_pending, st.acc,
                                          st.status, 2'h0,
                                          st.fetch_addr}; // [RQ11]
            default: next_st.prdata = 32'h00000000;
         endcase
      end
      if (access && pwrite && paddr == `OFF_COUNTER_LOW) begin
         next_st.pcl_req = 1'b1; // [RQ7] [RQ9]
         next_st.pcl_val = pwdata[7:0];
      end
      if (access && pwrite && paddr == `OFF_CONTROL) begin
         next_st.run = pwdata[`CTRL_RUN_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
         st.phase <= PH_T1;
         st.run <= `CTRL_RUN_RESET;
         st.fetch_addr <= `RESET_PC; // [RQ21]
         st.level <= 2'h0; // [RQ14]
      end else begin
         st <= next_st;
      end
   end

   // ***************************************
   // Outputs
   // ***************************************
   assign pready = 1'b1;
   assign prdata = st.prdata;
   assign pslverr = st.pslverr;
   assign pmem_addr = st.fetch_addr;
   assign dmem_addr = st.dmem_addr;
   assign dmem_wdata = st.dmem_wdata;
   assign dmem_we = st.dmem_we;
   assign irq_ack = st.irq_ack;
   assign instruction_phase_clocks = 4'h1 << st.phase; // [RQ1]

   // ***************************************
   // Assertions
   // ***************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_runs3;
      st.run [*3];
   endsequence

   sequence s_plain_end;
      step_end && !st.redir && !st.pcl_req && !ack_ok;
   endsequence

   sequence s_branch_end;
      step_end && st.redir && !st.pcl_req;
   endsequence

   phase_onehot_a: assert property ( // [RQ1]
      $onehot(instruction_phase_clocks))
      else $error("phase clocks not one-hot");

   phase_ring_a: assert property ( // [RQ1]
      (st.phase == PH_T1) ##0 s_runs3 |=> st.phase == PH_T4)
      else $error("phase sequence broken");

   fetch_step_a: assert property ( // [RQ6]
      s_plain_end |=> st.fetch_addr == $past(seq_pc) && st.ir_valid)
      else $error("counter did not step by one");

   counter_wrap_a: assert property ( // [RQ22]
      s_plain_end ##0 st.fetch_addr == 10'h3FF |=> st.fetch_addr == 10'h000)
      else $error("counter did not wrap to zero");

   fetch_overlap_a: assert property ( // [RQ3]
      s_plain_end |=> st.ir == $past(pmem_rdata))
      else $error("prefetched word not taken");

   branch_flush_a: assert property ( // [RQ4]
      s_branch_end |=> !st.ir_valid && st.fetch_addr == $past(st.target))
      else $error("branch did not flush and redirect");

   pcl_page_a: assert property ( // [RQ9]
      step_end && st.pcl_req |=> st.fetch_addr == $past(pcl_target)
      && !st.ir_valid)
      else $error("low byte branch wrong");

   stack_push_a: assert property ( // [RQ12]
      step_end && (st.push || ack_ok) && st.level != 2'h2
      |=> st.level == $past(st.level) + 2'h1)
      else $error("push did not raise level");

   stack_over_a: assert property ( // [RQ16]
      step_end && st.push && st.level == 2'h2 |=> st.level == 2'h2
      && st.stack[1] == $past(st.fetch_addr)
      && st.stack[0] == $past(st.stack[1]))
      else $error("overflow did not drop oldest");

   stack_pop_a: assert property ( // [RQ13]
      s_branch_end ##0 st.pop && st.level != 2'h0
      |=> st.fetch_addr == $past(top_ret)
      && st.level == $past(st.level) - 2'h1)
      else $error("return did not restore counter");

   irq_defer_a: assert property ( // [RQ15]
      st.irq_pending && st.level == 2'h2 |=> !irq_ack && st.irq_pending)
      else $error("interrupt taken on full stack");

   write_phase_a: assert property ( // [RQ19]
      dmem_we |-> st.phase == PH_T4 || !st.run)
      else $error("data write outside fourth phase");
endmodule

// [hw/seq_alu.sv]
// Combinational 8-bit arithmetic and logic unit with status flags
`timescale 1ns/1ps
module seq_alu (
   // Operation and result
   alu_if.unit bus
);
   import seq_pkg::*;
   logic sub;
   logic ci;
   logic [`DW-1:0] bb;
   logic [`DW:0] sum;
   logic [4:0] low;
   logic [`DW:0] dadj;
   logic [`DW-1:0] y;
   logic [3:0] fl;
   logic [3:0] up;
   always_comb begin
      sub = (bus.func == F_SUB) || (bus.func == F_SBC);
      bb = sub ? ~bus.b : bus.b;
      ci = sub;
      if (bus.func == F_ADC || bus.func == F_SBC) begin
         ci = bus.sin[`ST_C];
      end
      sum = {1'b0, bus.a} + {1'b0, bb} + {8'h00, ci};
      low = {1'b0, bus.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
      // Decimal adjust works on the accumulator
      dadj = {1'b0, bus.a};
      if (bus.a[3:0] > 4'h9 || bus.sin[`ST_AC]) begin
         dadj = dadj + 9'h006;
      end
      if (dadj[7:4] > 4'h9 || bus.sin[`ST_C] || dadj[8]) begin
         dadj = dadj + 9'h060;
      end
      fl = 4'h0;
      fl[`ST_C] = sum[8];
      fl[`ST_AC] = low[4];
      fl[`ST_OV] = (bus.a[7] == bb[7]) && (sum[7] != bus.a[7]);
      up = 4'h0;
      y = 8'h00;
      unique case (bus.func)
         F_MOV: y = bus.dest_mem ? bus.a : bus.b;
         F_ADD, F_ADC, F_SUB, F_SBC: begin
            y = sum[7:0];
            up = 4'hF;
         end
         F_DAA: begin
            y = dadj[7:0];
            fl[`ST_C] = dadj[8] | bus.sin[`ST_C];
            up[`ST_C] = 1'b1;
         end
         F_AND: y = bus.a & bus.b;
         F_OR: y = bus.a | bus.b;
         F_XOR: y = bus.a ^ bus.b;
         F_CPL: y = ~bus.b;
         F_RR: y = {bus.b[0], bus.b[7:1]};
         F_RL: y = {bus.b[6:0], bus.b[7]};
         F_RRC: begin
            y = {bus.sin[`ST_C], bus.b[7:1]};
            fl[`ST_C] = bus.b[0];
            up[`ST_C] = 1'b1;
         end
         F_RLC: begin
            y = {bus.b[6:0], bus.sin[`ST_C]};
            fl[`ST_C] = bus.b[7];
            up[`ST_C] = 1'b1;
         end
         F_INC: y = bus.b + 8'h01;
         F_DEC: y = bus.b - 8'h01;
      endcase
      // Logic, complement and step operations only touch zero
      if (bus.func inside {F_AND, F_OR, F_XOR, F_CPL, F_INC, F_DEC}) begin
         up[`ST_Z] = 1'b1;
      end
      fl[`ST_Z] = (y == 8'h00);
      bus.y = y;
      bus.flags = fl;
      bus.upd = up;
   end
endmodule

// [hw/seq_consts.svh]
// Offsets, field positions, reset values and widths of the sequencer
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH
// ***************************************
// Widths
// ***************************************
`define PC_W 10
`define IR_W 14
`define DW 8
// ***************************************
// APB byte offsets, control fields and counter reset value
// ***************************************
`define OFF_COUNTER_LOW 8'h00
`define OFF_CONTROL 8'h04
`define OFF_STATE 8'h08
`define CTRL_RUN_BIT 0
`define CTRL_RUN_RESET 1'b1
`define RESET_PC 10'h000
// ***************************************
// Internal data addresses and status bits
// ***************************************
`define DADDR_IND 8'h00
`define DADDR_PTR 8'h01
`define DADDR_PCL 8'h06
`define DADDR_STATUS 8'h0A
`define ST_C 0
`define ST_AC 1
`define ST_Z 2
`define ST_OV 3
// ***************************************
// Instruction fields
// ***************************************
`define IR_BRANCH 13
`define IR_MISC 12
`define IR_CALL 11
`define IR_DEST 8
`define SUB_SZ 3'h0
`define SUB_SNZ 3'h1
`define SUB_SIZ 3'h2
`define SUB_SDZ 3'h3
`define SUB_RET 3'h4
`define SUB_INTERRUPT_RETURN 3'h5
`endif

// [hw/seq_pkg.sv]
// Types shared by the sequencer and its arithmetic unit
`include "seq_consts.svh"
package seq_pkg;
   typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} phase_e;
   typedef enum logic [3:0] {
      F_MOV, F_ADD, F_ADC, F_SUB, F_SBC, F_DAA, F_AND, F_OR,
      F_XOR, F_CPL, F_RR, F_RL, F_RRC, F_RLC, F_INC, F_DEC
   } alu_func_e;
   typedef struct packed {
      phase_e phase;
      logic run;
      logic [`PC_W-1:0] fetch_addr;
      logic [`IR_W-1:0] ir;
      logic ir_valid;
      logic [`DW-1:0] acc;
      logic [3:0] status;
      logic [`DW-1:0] ptr;
      logic [1:0][`PC_W-1:0] stack;
      logic [1:0] level;
      logic irq_pending;
      logic irq_ack;
      logic pcl_req;
      logic [`DW-1:0] pcl_val;
      logic redir;
      logic [`PC_W-1:0] target;
      logic push;
      logic pop;
      logic [`DW-1:0] dmem_addr;
      logic [`DW-1:0] dmem_wdata;
      logic dmem_we;
      logic [31:0] prdata;
      logic pslverr;
   } seq_state_s;
endpackage

// [verif/mcu_fetch_sequencer_stack_tb.sv]
// Self-checking bench for the fetch sequencer
`timescale 1ns/1ps
`include "seq_consts.svh"
module mcu_fetch_sequencer_stack_tb;
   import seq_pkg::*;
   localparam logic [9:0] VEC = 10'h0C0;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic irq_event, irq_ack, dmem_we;
   logic [7:0] paddr, dmem_addr, dmem_wdata, dmem_rdata, va, vb, tgt;
   logic [31:0] pwdata, prdata, rd;
   logic [9:0] pmem_addr;
   logic [13:0] pmem_rdata;
   logic [3:0] instruction_phase_clocks;
   logic [8:0] sum;
   logic [10:0] trace [$];
   int bad_count, check_count, seed;
   logic [9:0] exp_pc [26] = '{10'h000, 10'h001, 10'h010, 10'h011,
      10'h012, 10'h013, 10'h014, 10'h020, 10'h021, 10'h030, 10'h031,
      10'h038, 10'h039, 10'h031, 10'h032, 10'h021, 10'h022, 10'h014,
      10'h015, 10'h016, 10'h017, 10'h3FE, 10'h3FF, 10'h000, 10'h001,
      10'h010};

   fetch_sequencer #(.IRQ_VECTOR(VEC)) uut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
      .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_we(dmem_we),
      .dmem_rdata(dmem_rdata), .irq_event(irq_event), .irq_ack(irq_ack),
      .instruction_phase_clocks(instruction_phase_clocks));
   mem_model mem (.pclk(pclk), .pmem_addr(pmem_addr),
      .pmem_rdata(pmem_rdata), .dmem_addr(dmem_addr),
      .dmem_wdata(dmem_wdata), .dmem_we(dmem_we), .dmem_rdata(dmem_rdata));

   // ***************************************
   // Clock, fetch trace and watchdog
   // ***************************************
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // One entry per instruction cycle, taken mid-T1
   always @(negedge pclk) begin
      if (presetn === 1'b1 && instruction_phase_clocks === 4'b0001) begin
         trace.push_back({irq_ack, pmem_addr});
      end
   end
   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      $display("unexpected timeout");
      print_verdict();
   end

   // ***************************************
   // Helpers
   // ***************************************
   function automatic logic [13:0] unconditional_jump(logic [9:0] t);
      return {4'b1000, t};
   endfunction
   function automatic logic [13:0] call(logic [9:0] t);
      return {4'b1010, t};
   endfunction
   function automatic logic [13:0] misc(logic [2:0] s, logic [7:0] a);
      return {3'b110, s, a};
   endfunction
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Starts one edge after entry so back-to-back calls never clash
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_pc(logic [9:0] a);
      int n;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (!(instruction_phase_clocks === 4'b0001 &&
                   pmem_addr === a) && n < 4000);
      chk("reach", 32'(pmem_addr), 32'(a));
   endtask
   task automatic wait_len(int n);
      int k;
      k = 0;
      while (trace.size() < n && k < 4000) begin
         @(negedge pclk);
         k++;
      end
      chk("trace length", 32'(trace.size()), 32'(n));
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ***************************************
   // Main sequence
   // ***************************************
   initial begin
      seed = 35713;
      bad_count = 0;
      check_count = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      irq_event = 1'b0;
      va = 8'($random(seed));
      vb = 8'($random(seed));
      tgt = 8'($random(seed));
      sum = {1'b0, va} + {1'b0, vb};
      for (int i = 0; i < 1024; i++) begin
         mem.rom[i] = misc(3'h7, 8'h00);
      end
      mem.ram[8'h40] = va;
      mem.ram[8'h42] = vb;
      mem.ram[8'h43] = 8'h00;
      mem.ram[8'h44] = 8'h00;
      mem.rom[10'h000] = unconditional_jump(10'h010);
      mem.rom[10'h010] = {1'b0, F_MOV, 1'b0, 8'h40};
      mem.rom[10'h011] = {1'b0, F_ADD, 1'b0, 8'h42};
      mem.rom[10'h012] = {1'b0, F_MOV, 1'b1, 8'h43};
      mem.rom[10'h013] = call(10'h020);
      mem.rom[10'h014] = misc(`SUB_SZ, 8'h44);
      mem.rom[10'h015] = unconditional_jump(10'h015);
      mem.rom[10'h016] = unconditional_jump(10'h3FE);
      mem.rom[10'h020] = call(10'h030);
      mem.rom[10'h021] = unconditional_jump(10'h014);
      // Third nesting level overflows on purpose
      mem.rom[10'h030] = call(10'h038);
      mem.rom[10'h031] = misc(`SUB_RET, 8'h00);
      mem.rom[10'h038] = misc(`SUB_RET, 8'h00);
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      wait_len(26);
      for (int i = 0; i < 26; i++) begin
         chk("fetch", 32'(trace[i]), 32'(exp_pc[i]));
      end
      $display("test pipeline done");
      apb(1'b0, `OFF_STATE, 32'h0);
      chk("acc", 32'(rd[23:16]), 32'(sum[7:0]));
      chk("carry", 32'(rd[12 + `ST_C]), 32'(sum[8]));
      chk("stored", 32'(mem.ram[8'h43]), 32'(sum[7:0]));
      apb(1'b0, 8'h0C, 32'hFFFF_FFFF);
      chk("unmapped err", 32'(err), 32'h1);
      chk("unmapped data", rd, 32'h0);
      $display("test alu and registers done");
      wait_pc(10'h3FE);
      apb(1'b1, `OFF_COUNTER_LOW, 32'(tgt));
      trace.delete();
      wait_len(2);
      chk("low byte jump", 32'(trace[0]), 32'({3'b011, tgt}));
      chk("after jump", 32'(trace[1]), 32'(10'({2'b11, tgt} + 10'h1)));
      $display("test counter low byte done");
      wait_pc(10'h038);
      @(posedge pclk);
      irq_event <= 1'b1;
      trace.delete();
      @(posedge pclk);
      irq_event <= 1'b0;
      wait_len(3);
      chk("irq held", 32'(trace[0]), 32'({1'b0, 10'h039}));
      chk("irq held", 32'(trace[1]), 32'({1'b0, 10'h031}));
      chk("irq taken", 32'(trace[2]), 32'({1'b1, VEC}));
      $display("test deferred interrupt done");
      print_verdict();
   end
endmodule

// [verif/mem_model.sv]
// Program and data memory model facing the sequencer
`timescale 1ns/1ps
`include "seq_consts.svh"
module mem_model (
   // Clock
   input wire logic pclk,
   // Program side
   input wire logic [`PC_W-1:0] pmem_addr,
   output logic [`IR_W-1:0] pmem_rdata,
   // Data side
   input wire logic [`DW-1:0] dmem_addr,
   input wire logic [`DW-1:0] dmem_wdata,
   input wire logic dmem_we,
   output logic [`DW-1:0] dmem_rdata
);
   logic [`IR_W-1:0] rom [0:1023];
   logic [`DW-1:0] ram [0:255];
   // Zero latency: the core samples data inside T3
   assign pmem_rdata = rom[pmem_addr];
   assign dmem_rdata = ram[dmem_addr];
   always @(posedge pclk) begin
      if (dmem_we === 1'b1) begin
         ram[dmem_addr] <= dmem_wdata;
      end
   end
endmodule
